// ---- pkg/igo_pkg.sv ----
package igo_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_INPUT_CFG    = 6'h05;
  localparam logic [5:0] IDX_RED_GAIN     = 6'h06;
  localparam logic [5:0] IDX_GREEN_GAIN   = 6'h07;
  localparam logic [5:0] IDX_BLUE_GAIN    = 6'h08;
  localparam logic [5:0] IDX_RED_OFFSET   = 6'h09;
  localparam logic [5:0] IDX_GREEN_OFFSET = 6'h0a;
  localparam logic [5:0] IDX_BLUE_OFFSET  = 6'h0b;
  localparam logic [5:0] IDX_OFS_CONV_CFG = 6'h0c;
  localparam logic [5:0] IDX_STATUS       = 6'h0d;
  localparam logic [5:0] IDX_CTRL         = 6'h0e;
  localparam int         ADDR_W           = 8;

  // Reset values
  localparam logic [7:0] RST_INPUT_CFG = 8'h00;
  localparam logic [7:0] RST_GAIN      = 8'h55;
  localparam logic [7:0] RST_OFFSET    = 8'h80;
  localparam logic [7:0] RST_OFS_CFG   = 8'h00;
  localparam logic [7:0] RST_CTRL      = 8'h00;

  // Input configuration field positions
  localparam int BIT_PORT_SEL    = 0;
  localparam int BIT_COUPLING    = 1;
  localparam int BIT_COLOUR      = 2;
  localparam int BIT_SYNC_TYPE   = 3;
  localparam int BIT_COMP_SRC    = 4;
  localparam int BIT_HOLD_CLAMP  = 5;
  localparam logic [7:0] MASK_INPUT_CFG = 8'h3f;

  // Offset converter configuration fields
  localparam int BIT_OFS_RANGE   = 0;
  localparam int LSB_RED_LOW     = 2;
  localparam int LSB_GREEN_LOW   = 4;
  localparam int LSB_BLUE_LOW    = 6;
  localparam logic [7:0] MASK_OFS_CFG = 8'hfd;

  // Control register (auto black level enable)
  localparam int BIT_ABL_EN      = 0;
  localparam logic [7:0] MASK_CTRL = 8'h01;

  // Clamp levels in mV, and black-level targets
  localparam logic [9:0] CLAMP_MV_LOW   = 10'd300;
  localparam logic [9:0] CLAMP_MV_HIGH  = 10'd600;
  localparam logic [7:0] TARGET_ZERO    = 8'h00;
  localparam logic [7:0] TARGET_MID     = 8'h80;

  // Gain law: gain = 0.5 + code/170, expressed in thousandths
  localparam int GAIN_BASE_MILLI = 500;
  localparam int GAIN_DIV        = 170;

  // Sync multiplexer source encoding
  typedef enum logic [1:0] {
    IGO_SRC_HSYNC = 2'b00,
    IGO_SRC_SOG   = 2'b01
  } igo_sync_src_t;

  // Bus answer state
  typedef enum logic [1:0] {
    IGO_IDLE = 2'b00,
    IGO_ACK  = 2'b01
  } igo_bus_st_t;
endpackage

// ---- hdl/igo_offset_path.sv ----
`timescale 1ns/1ps
// One channel's offset path: digital offset or 10-bit converter code
module igo_offset_path
  import igo_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        abl_en,
  input  wire logic        load,
  input  wire logic [7:0]  ofs_code,
  input  wire logic [1:0]  low_bits,
  input  wire logic [7:0]  adc_in,
  output logic      [9:0]  dac_code,
  output logic      [7:0]  adc_out
);

  // Signed offset from offset-binary code
  logic signed [8:0] dig_ofs;
  logic signed [9:0] sum;

  assign dig_ofs = $signed({1'b0, ofs_code}) - $signed({1'b0, RST_OFFSET});
  assign sum     = $signed({2'b00, adc_in}) + 10'(dig_ofs);

  // Converter code moves only on clamp strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_code <= {RST_OFFSET, 2'b00};
    end else if (load) begin
      dac_code <= {ofs_code, low_bits};
    end
  end

  // Output code, saturated to 8 bits; one code step per register step
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adc_out <= 8'h00;
    end else if (!abl_en) begin
      adc_out <= adc_in;
    end else if (sum < 0) begin
      adc_out <= 8'h00;
    end else if (sum > 10'sd255) begin
      adc_out <= 8'hff;
    end else begin
      adc_out <= sum[7:0];
    end
  end

  // Step of one in register gives step of one at output; saturated
  // codes and the wrap from 0xff to 0x00 are left out on purpose
  a_ofs_step: assert property (@(posedge clk) disable iff (!arst_n)
    abl_en && $past(abl_en) && $stable(adc_in)
      && ofs_code == $past(ofs_code) + 8'h01 && ofs_code != 8'h00
      && adc_out != 8'h00 && adc_out != 8'hff
    |=> adc_out == $past(adc_out) + 8'h01)
    else $error("offset step mismatch");

endmodule

// ---- hdl/igo_config_top.sv ----
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module igo_config_top
  import igo_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Timing inputs from the front end
  input  wire logic              clamp_strobe_in,
  input  wire logic              clock_hold,
  input  wire logic              hsync_in,
  input  wire logic              sync_on_green_input,
  // Raw converter codes, one per channel
  input  wire logic [7:0]        adc_red,
  input  wire logic [7:0]        adc_green,
  input  wire logic [7:0]        adc_blue,
  // Analog front end controls
  output logic                   input_port_b,
  output logic                   pos_to_clamp,
  output logic                   neg_tied_clamp,
  output logic                   analog_clamp,
  output logic      [9:0]        clamp_mv_red,
  output logic      [9:0]        clamp_mv_green,
  output logic      [9:0]        clamp_mv_blue,
  output logic      [2:0]        half_shift,
  output logic      [7:0]        target_red,
  output logic      [7:0]        target_green,
  output logic      [7:0]        target_blue,
  output logic                   composite_sync,
  output logic                   sync_out,
  output logic                   abl_start,
  output logic                   ofs_range_quarter,
  output logic      [7:0]        gain_red,
  output logic      [7:0]        gain_green,
  output logic      [7:0]        gain_blue,
  output logic      [9:0]        dac_red,
  output logic      [9:0]        dac_green,
  output logic      [9:0]        dac_blue,
  output logic      [7:0]        out_red,
  output logic      [7:0]        out_green,
  output logic      [7:0]        out_blue
);

  // Register storage
  logic [7:0] input_configuration;
  logic [7:0] red_gain;
  logic [7:0] green_gain;
  logic [7:0] blue_gain;
  logic [7:0] red_offset;
  logic [7:0] green_offset;
  logic [7:0] blue_offset;
  logic [7:0] offset_converter_config;
  logic [7:0] ctrl;                    // Auto correction enable
  // Synchronisers for pin inputs
  logic [1:0] strobe_sync;
  logic [1:0] hold_sync;
  logic [1:0] hs_sync;
  logic [1:0] sog_sync;
  logic       strobe_q;
  // Bus
  igo_bus_st_t bus_st;
  logic        req;
  logic [5:0]  idx;
  logic        lane0;
  logic        clamp_ok;
  logic        load_pulse;
  logic        abl_en;

  // Word index from byte address
  function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[ADDR_W-1:2];
  endfunction

  // Merge writes into lane 0 with a mask of implemented bits
  function automatic logic [7:0] wr_val(input logic [7:0] d,
                                        input logic [7:0] m);
    wr_val = d & m;
  endfunction

  assign req   = avs_read | avs_write;
  assign idx   = word_idx(avs_address);
  assign lane0 = avs_byteenable[0];
  assign abl_en = ctrl[BIT_ABL_EN];

  // One wait cycle, then answer; request completes on second edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_st <= IGO_IDLE;
    end else begin
      unique case (bus_st)
        IGO_IDLE: bus_st <= req ? IGO_ACK : IGO_IDLE;
        IGO_ACK:  bus_st <= IGO_IDLE;
        default:  bus_st <= IGO_IDLE;
      endcase
    end
  end

  assign avs_waitrequest = req && (bus_st != IGO_ACK);

  // Register writes at the completing edge only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      input_configuration     <= RST_INPUT_CFG;
      red_gain                <= RST_GAIN;
      green_gain              <= RST_GAIN;
      blue_gain               <= RST_GAIN;
      red_offset              <= RST_OFFSET;
      green_offset            <= RST_OFFSET;
      blue_offset             <= RST_OFFSET;
      offset_converter_config <= RST_OFS_CFG;
      ctrl                    <= RST_CTRL;
    end else if (avs_write && bus_st == IGO_ACK && lane0) begin
      unique case (idx)
        // Reserved bits are dropped so they read as zero
        IDX_INPUT_CFG: input_configuration <=
          wr_val(avs_writedata[7:0], MASK_INPUT_CFG);
        IDX_RED_GAIN:     red_gain     <= avs_writedata[7:0];
        IDX_GREEN_GAIN:   green_gain   <= avs_writedata[7:0];
        IDX_BLUE_GAIN:    blue_gain    <= avs_writedata[7:0];
        IDX_RED_OFFSET:   red_offset   <= avs_writedata[7:0];
        IDX_GREEN_OFFSET: green_offset <= avs_writedata[7:0];
        IDX_BLUE_OFFSET:  blue_offset  <= avs_writedata[7:0];
        IDX_OFS_CONV_CFG: offset_converter_config <=
          wr_val(avs_writedata[7:0], MASK_OFS_CFG);
        IDX_CTRL: ctrl <= wr_val(avs_writedata[7:0], MASK_CTRL);
        default: ;
      endcase
    end
  end

  // Read data registered at the wait cycle; unmapped reads zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && bus_st == IGO_IDLE) begin
      unique case (idx)
        IDX_INPUT_CFG:    avs_readdata <= {24'h0, input_configuration};
        IDX_RED_GAIN:     avs_readdata <= {24'h0, red_gain};
        IDX_GREEN_GAIN:   avs_readdata <= {24'h0, green_gain};
        IDX_BLUE_GAIN:    avs_readdata <= {24'h0, blue_gain};
        IDX_RED_OFFSET:   avs_readdata <= {24'h0, red_offset};
        IDX_GREEN_OFFSET: avs_readdata <= {24'h0, green_offset};
        IDX_BLUE_OFFSET:  avs_readdata <= {24'h0, blue_offset};
        IDX_OFS_CONV_CFG: avs_readdata <= {24'h0,
                                           offset_converter_config};
        IDX_STATUS:       avs_readdata <= {29'h0, clamp_ok,
                                           sync_out, composite_sync};
        IDX_CTRL:         avs_readdata <= {24'h0, ctrl};
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Two-stage synchronisers for pin inputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_sync <= 2'b00;
      hold_sync   <= 2'b00;
      hs_sync     <= 2'b00;
      sog_sync    <= 2'b00;
    end else begin
      strobe_sync <= {strobe_sync[0], clamp_strobe_in};
      hold_sync   <= {hold_sync[0], clock_hold};
      hs_sync     <= {hs_sync[0], hsync_in};
      sog_sync    <= {sog_sync[0], sync_on_green_input};
    end
  end

  // Previous strobe level for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe_sync[1];
    end
  end

  // Clamping and correction paused in hold unless enabled
  assign clamp_ok = !hold_sync[1]
                    || input_configuration[BIT_HOLD_CLAMP];
  // Converter load is on every strobe start, regardless of hold
  assign load_pulse = strobe_sync[1] && !strobe_q;

  // Analog routing and clamp strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      input_port_b   <= 1'b0;
      pos_to_clamp   <= 1'b0;
      neg_tied_clamp <= 1'b1;
      analog_clamp   <= 1'b0;
      abl_start      <= 1'b0;
    end else begin
      input_port_b <= input_configuration[BIT_PORT_SEL];
      if (input_configuration[BIT_COUPLING]) begin
        // DC: pads only, clamp never applied
        pos_to_clamp   <= 1'b0;
        neg_tied_clamp <= 1'b0;
        analog_clamp   <= 1'b0;
      end else begin
        // AC: positive tied only during clamp interval
        pos_to_clamp   <= strobe_sync[1] && clamp_ok;
        neg_tied_clamp <= 1'b1;
        analog_clamp   <= strobe_sync[1] && clamp_ok;
      end
      abl_start <= load_pulse && abl_en && clamp_ok;
    end
  end

  // Colour space: clamp level, shift and black target
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clamp_mv_red   <= CLAMP_MV_LOW;
      clamp_mv_green <= CLAMP_MV_LOW;
      clamp_mv_blue  <= CLAMP_MV_LOW;
      half_shift     <= 3'b111;
      target_red     <= TARGET_ZERO;
      target_green   <= TARGET_ZERO;
      target_blue    <= TARGET_ZERO;
    end else if (input_configuration[BIT_COLOUR]) begin
      clamp_mv_red   <= CLAMP_MV_HIGH;
      clamp_mv_green <= CLAMP_MV_LOW;
      clamp_mv_blue  <= CLAMP_MV_HIGH;
      half_shift     <= 3'b010;
      target_red     <= TARGET_MID;
      target_green   <= TARGET_ZERO;
      target_blue    <= TARGET_MID;
    end else begin
      clamp_mv_red   <= CLAMP_MV_LOW;
      clamp_mv_green <= CLAMP_MV_LOW;
      clamp_mv_blue  <= CLAMP_MV_LOW;
      half_shift     <= 3'b111;
      target_red     <= TARGET_ZERO;
      target_green   <= TARGET_ZERO;
      target_blue    <= TARGET_ZERO;
    end
  end

  // Sync multiplexer; separate mode always passes hsync
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      composite_sync <= 1'b0;
      sync_out       <= 1'b0;
    end else begin
      composite_sync <= input_configuration[BIT_SYNC_TYPE];
      if (input_configuration[BIT_SYNC_TYPE]
          && !input_configuration[BIT_COMP_SRC]) begin
        sync_out <= sog_sync[1];
      end else begin
        sync_out <= hs_sync[1];
      end
    end
  end

  // Gain codes go straight to the amplifiers; law is analog
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_red          <= RST_GAIN;
      gain_green        <= RST_GAIN;
      gain_blue         <= RST_GAIN;
      ofs_range_quarter <= 1'b0;
    end else begin
      gain_red          <= red_gain;
      gain_green        <= green_gain;
      gain_blue         <= blue_gain;
      ofs_range_quarter <= offset_converter_config[BIT_OFS_RANGE];
    end
  end

  // Per-channel offset paths
  igo_offset_path u_red (
    .clk      (clk),
    .arst_n   (arst_n),
    .abl_en   (abl_en),
    .load     (load_pulse),
    .ofs_code (red_offset),
    .low_bits (offset_converter_config[LSB_RED_LOW +: 2]),
    .adc_in   (adc_red),
    .dac_code (dac_red),
    .adc_out  (out_red)
  );
  igo_offset_path u_green (
    .clk      (clk),
    .arst_n   (arst_n),
    .abl_en   (abl_en),
    .load     (load_pulse),
    .ofs_code (green_offset),
    .low_bits (offset_converter_config[LSB_GREEN_LOW +: 2]),
    .adc_in   (adc_green),
    .dac_code (dac_green),
    .adc_out  (out_green)
  );
  igo_offset_path u_blue (
    .clk      (clk),
    .arst_n   (arst_n),
    .abl_en   (abl_en),
    .load     (load_pulse),
    .ofs_code (blue_offset),
    .low_bits (offset_converter_config[LSB_BLUE_LOW +: 2]),
    .adc_in   (adc_blue),
    .dac_code (dac_blue),
    .adc_out  (out_blue)
  );

  // Assertions
  a_port_select: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 input_port_b == $past(input_configuration[BIT_PORT_SEL]))
    else $error("port select not followed");
  a_dc_no_clamp: assert property (@(posedge clk) disable iff (!arst_n)
    input_configuration[BIT_COUPLING]
      && $past(input_configuration[BIT_COUPLING])
    |-> !analog_clamp && !pos_to_clamp)
    else $error("clamp active in DC mode");
  a_ac_neg_tie: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(input_configuration[BIT_COUPLING]) |-> neg_tied_clamp)
    else $error("negative input not tied");
  a_yuv_levels: assert property (@(posedge clk) disable iff (!arst_n)
    $past(input_configuration[BIT_COLOUR])
    |-> clamp_mv_red == CLAMP_MV_HIGH && target_blue == TARGET_MID
        && half_shift == 3'b010)
    else $error("colour space outputs wrong");
  a_rgb_levels: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(input_configuration[BIT_COLOUR])
    |-> clamp_mv_blue == CLAMP_MV_LOW && target_red == TARGET_ZERO)
    else $error("RGB outputs wrong");
  a_sep_hsync: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(input_configuration[BIT_SYNC_TYPE])
    |-> sync_out == $past(hs_sync[1]))
    else $error("separate sync must pass hsync");
  a_dac_load: assert property (@(posedge clk) disable iff (!arst_n)
    load_pulse |=> dac_red == {$past(red_offset),
                   $past(offset_converter_config[LSB_RED_LOW +: 2])})
    else $error("converter code not loaded");
  a_hold_pause: assert property (@(posedge clk) disable iff (!arst_n)
    !clamp_ok |=> !abl_start)
    else $error("correction ran during hold");
  a_gain_reset: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arst_n) |-> red_gain == RST_GAIN)
    else $error("gain reset wrong");

endmodule

// ---- dv/igo_config_tb.sv ----
`timescale 1ns/1ps
module testbench
  import igo_pkg::*;
;
  // Clock, reset and bus
  logic              clk;
  logic              arst_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read, avs_write, avs_waitrequest;
  logic [31:0]       avs_writedata, avs_readdata;
  logic [3:0]        avs_byteenable;
  // Front end pins and converter codes
  logic              clamp_strobe_in, clock_hold, hsync_in;
  logic              sync_on_green_input;
  logic [7:0]        adc_red, adc_green, adc_blue;
  // Observed controls
  logic              input_port_b, pos_to_clamp, neg_tied_clamp;
  logic              analog_clamp, composite_sync, sync_out;
  logic              abl_start, ofs_range_quarter;
  logic [9:0]        clamp_mv_red, clamp_mv_green, clamp_mv_blue;
  logic [2:0]        half_shift;
  logic [7:0]        target_red, target_green, target_blue;
  logic [7:0]        gain_red, gain_green, gain_blue;
  logic [9:0]        dac_red, dac_green, dac_blue;
  logic [7:0]        out_red, out_green, out_blue;
  // Bookkeeping
  int                miscompares, cmp_count;
  logic [31:0]       lfsr;
  logic [7:0]        shadow [16];

  igo_config_top dut_u (
    .clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .clamp_strobe_in,
    .clock_hold, .hsync_in, .sync_on_green_input, .adc_red, .adc_green,
    .adc_blue, .input_port_b, .pos_to_clamp, .neg_tied_clamp, .analog_clamp,
    .clamp_mv_red, .clamp_mv_green, .clamp_mv_blue, .half_shift, .target_red,
    .target_green, .target_blue, .composite_sync, .sync_out, .abl_start,
    .ofs_range_quarter, .gain_red, .gain_green, .gain_blue, .dac_red,
    .dac_green, .dac_blue, .out_red, .out_green, .out_blue
  );

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // Next random word
  function automatic void rnd(output logic [7:0] r);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    r = lfsr[7:0];
  endfunction

  // Expected saturated sum of code and offset-binary offset
  function automatic logic [7:0] sat_add(input logic [7:0] a,
                                         input logic [7:0] o);
    int s;
    s = int'(a) + int'(o) - 128;
    if (s < 0) s = 0;
    if (s > 255) s = 255;
    return s[7:0];
  endfunction

  // Bits that survive a write; reserved bits read back zero
  function automatic logic [7:0] wmask(input int i);
    case (i)
      5: return 8'h3f;
      12: return 8'hfd;
      14: return 8'h01;
      default: return 8'hff;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle; entered just after a rising edge, held until accepted
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [7:0] d, input logic [3:0] be,
                     output logic [7:0] q);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    // Waitrequest and read data seen as they stood at this edge
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // One idle edge before the next request may rise
    @(posedge clk);
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i[5:0], d, 4'h1, q);
    shadow[i] = d & wmask(i);
  endtask

  // Let synchronisers and output registers settle, sample mid-cycle
  task automatic settle();
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog; the full sequence needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    logic [7:0] q, r, e, o;
    logic [5:0] v;
    logic       h, en, cl;
    logic [9:0] dexp [3];
    int         n;
    clk = 1'b0; arst_n = 1'b0; avs_address = '0; avs_read = 1'b0;
    avs_write = 1'b0; avs_writedata = '0; avs_byteenable = '0;
    clamp_strobe_in = 1'b0; clock_hold = 1'b0; hsync_in = 1'b0;
    sync_on_green_input = 1'b0; adc_red = '0; adc_green = '0;
    adc_blue = '0; lfsr = 32'h6212; miscompares = 0; cmp_count = 0;
    dexp = '{10'h200, 10'h200, 10'h200};
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(gain_green, 8'h55);
    chk(dac_blue, 10'h200);
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // Register reset values, status skipped, one unmapped word
    for (int i = 5; i <= 15; i++) begin
      e = (i >= 6 && i <= 8) ? 8'h55 : (i >= 9 && i <= 11) ? 8'h80 : 8'h00;
      shadow[i] = e;
      if (i != 13) begin
        bus(1'b0, i[5:0], 8'h00, 4'h0, q);
        chk(q, e);
      end
    end
    // Random writes with read-back; reserved bits must drop
    repeat (24) begin
      rnd(r);
      rnd(o);
      wr(5 + int'(r[2:0]), o);
    end
    for (int i = 5; i <= 12; i++) begin
      bus(1'b0, i[5:0], 8'h00, 4'h0, q);
      chk(q, shadow[i]);
    end
    // A write with the low byte lane off changes nothing
    bus(1'b1, 6'h06, ~shadow[6], 4'h0, q);
    bus(1'b0, 6'h06, 8'h00, 4'h0, q);
    chk(q, shadow[6]);
    chk(gain_red, shadow[6]);
    chk(gain_blue, shadow[8]);
    // Every input configuration, with strobe, hold and correction mixed
    for (int k = 0; k < 64; k++) begin
      v = k[5:0];
      rnd(r);
      h = r[0];
      en = r[1];
      clock_hold <= h;
      hsync_in <= r[2];
      sync_on_green_input <= r[3];
      wr(5, {2'b00, v});
      wr(14, {7'h00, en});
      for (int c = 0; c < 4; c++) begin
        rnd(o);
        wr(9 + c, o);
      end
      settle();
      chk(input_port_b, v[0]);
      chk(neg_tied_clamp, !v[1]);
      chk(pos_to_clamp, 1'b0);
      chk(clamp_mv_red, v[2] ? 10'd600 : 10'd300);
      chk(clamp_mv_green, 10'd300);
      chk(clamp_mv_blue, v[2] ? 10'd600 : 10'd300);
      chk(half_shift, v[2] ? 3'b010 : 3'b111);
      chk(target_red, v[2] ? 8'h80 : 8'h00);
      chk(target_green, 8'h00);
      chk(target_blue, v[2] ? 8'h80 : 8'h00);
      chk(composite_sync, v[3]);
      chk(sync_out, (v[3] && !v[4]) ? r[3] : r[2]);
      chk(ofs_range_quarter, shadow[12][0]);
      chk({dac_red, dac_green, dac_blue}, {dexp[0], dexp[1], dexp[2]});
      @(posedge clk);
      clamp_strobe_in <= 1'b1;
      n = 0;
      for (int t = 0; t < 8; t++) begin
        @(negedge clk);
        if (abl_start === 1'b1) n++;
      end
      cl = !v[1] && (!h || v[5]);
      chk(analog_clamp, cl);
      chk(pos_to_clamp, cl);
      chk(n, (en && (!h || v[5])) ? 1 : 0);
      for (int c = 0; c < 3; c++) begin
        dexp[c] = {shadow[9 + c], shadow[12][2 * c + 2 +: 2]};
      end
      chk(dac_red, dexp[0]);
      chk(dac_green, dexp[1]);
      chk(dac_blue, dexp[2]);
      @(posedge clk);
      clamp_strobe_in <= 1'b0;
      repeat (4) @(posedge clk);
    end
    // Digital offset with saturation corners, then correction off
    wr(14, 8'h01);
    for (int k = 0; k < 12; k++) begin
      rnd(o);
      rnd(r);
      if (k == 0) o = 8'h00;
      if (k == 0) r = 8'h00;
      if (k == 1) o = 8'hff;
      if (k == 1) r = 8'hff;
      if (k == 2) o = 8'h80;
      wr(9, o);
      wr(10, o + 8'h01);
      wr(11, o - 8'h01);
      adc_red <= r;
      adc_green <= r;
      adc_blue <= ~r;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(out_red, sat_add(r, o));
      chk(out_green, sat_add(r, o + 8'h01));
      chk(out_blue, sat_add(~r, o - 8'h01));
      @(posedge clk);
      // One register step with the code held must give the new saturated sum at the output
      wr(9, o + 8'h01);
      @(negedge clk);
      chk(out_red, sat_add(r, o + 8'h01));
      @(posedge clk);
    end
    wr(14, 8'h00);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(out_red, adc_red);
    @(posedge clk);
    tally_and_finish();
  end
endmodule
